/* rtl/rx_fifo_level_map.vh */
// Register map, field positions, reset values and timing constants of the receive FIFO level block.
//
// Function
// - Writing one to the flag-clear bit of the control register clears the threshold flag, unless the flag is being set in the same cycle.
// - Writing zero to the flag-clear bit does nothing, and the bit always reads as zero.
// - The receive FIFO interrupt request is high only while the flag and its enable are both one.
// - The flag is set whenever the FIFO run bit is one and the five-bit byte count is equal to or above the five-bit level.
// - With the level at its reset value of zero, the flag sets as soon as the FIFO is enabled.
// - While the FIFO run bit is zero the FIFO pointer is forced to zero and held in reset.
// - The five-bit status field reports the held byte count, zero when empty, 16 when full.
// - The flag is read-only and is cleared only by reset or by a write of one to the flag-clear bit.
`ifndef RX_FIFO_LEVEL_MAP_VH
`define RX_FIFO_LEVEL_MAP_VH

// Byte offsets of the word registers.
`define REG_CTRL_OFS 12'h000
`define REG_EVT_STATUS_OFS 12'h004
`define REG_EVT_MASK_OFS 12'h008

// Field positions of the receive FIFO control and status register.
`define CTRL_LEVEL_LSB 0
`define CTRL_LEVEL_MSB 4
`define CTRL_IRQ_EN_BIT 5
`define CTRL_FLAG_CLR_BIT 6
`define CTRL_FLAG_BIT 7
`define CTRL_COUNT_LSB 8
`define CTRL_COUNT_MSB 12
`define CTRL_RUN_BIT 13

// Reset values.
`define RST_LEVEL 5'h00
`define RST_IRQ_EN 1'b0
`define RST_RUN 1'b0
`define RST_EVT_MASK 4'h0

// Event status bit positions.
`define EVT_THRESHOLD 0
`define EVT_FULL 1
`define EVT_OVERFLOW 2
`define EVT_EMPTIED 3

// Byte count of a full FIFO.
`define FIFO_FULL_COUNT 5'h10

// AHB transfer type and response codes.
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

// Read wait states inserted by the slave.
`define READ_WAIT_CYCLES 1

`endif

/* rtl/rx_threshold_flag.v */
// Sticky receive threshold flag with a set-wins clear.
`timescale 1ns/1ps
`default_nettype none
module rx_threshold_flag #(
  parameter CNT_W = 5
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire run_i,
  input wire [CNT_W-1:0] count_i,
  input wire [CNT_W-1:0] level_i,
  input wire clear_i,
  output reg flag_o,
  output wire set_pulse_o
);

  wire set_cond;

  // Comparing only while running keeps a held FIFO from flagging on a stale count.
  assign set_cond = run_i & (count_i >= level_i);

  // Marks the cycle in which the flag rises, for the event status register.
  assign set_pulse_o = set_cond & ~flag_o;

  // A set in the same cycle as a clear wins, so no crossing of the level is lost.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (set_cond) begin
      flag_o <= 1'b1;
    end else if (clear_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= flag_o;
    end
  end

endmodule
`default_nettype wire

/* rtl/rx_fifo_level_irq.v */
// Receive FIFO level interrupt block with an AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "rx_fifo_level_map.vh"
module rx_fifo_level_irq #(
  parameter ADDR_W = 12,
  parameter CNT_W = 5,
  parameter EVT_N = 4
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire hsel_i,
  input wire [ADDR_W-1:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire hreadyout_o,
  output wire hresp_o,
  output reg [31:0] hrdata_o,
  input wire [CNT_W-1:0] rx_fifo_byte_count_i,
  output wire rx_fifo_run_not_reset_o,
  output wire rx_fifo_ptr_reset_o,
  output wire rx_fifo_irq_o,
  output wire irq_o
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RWAIT = 3'b010;
  localparam [2:0] ST_RDONE = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;

  reg dp_write;
  reg [ADDR_W-1:0] dp_addr;

  reg [CNT_W-1:0] rx_threshold_level;
  reg rx_threshold_irq_enable;
  reg rx_fifo_run_not_reset;
  reg [EVT_N-1:0] evt_status;
  reg [EVT_N-1:0] evt_mask;
  reg [CNT_W-1:0] count_prev;

  wire take;
  wire wr_en;
  wire wr_ctrl;
  wire wr_status;
  wire wr_mask;
  wire rx_threshold_flag_clear;
  wire rx_threshold_flag;
  wire flag_set_pulse;
  wire [CNT_W-1:0] rx_fifo_byte_count;
  wire [EVT_N-1:0] evt_pulse;
  wire [EVT_N-1:0] evt_w1c;
  wire [15:0] ctrl_word;
  reg [31:0] read_word;

  // The slave takes a transfer only when the bus is ready and the type is NONSEQ or SEQ.
  assign take = hsel_i & htrans_i[`HTRANS_NONSEQ_BIT] & hready_i;

  // Writes complete with no wait state; the register update lands at the end of the data phase.
  assign wr_en = dp_write;
  assign wr_ctrl = wr_en & (dp_addr == `REG_CTRL_OFS);
  assign wr_status = wr_en & (dp_addr == `REG_EVT_STATUS_OFS);
  assign wr_mask = wr_en & (dp_addr == `REG_EVT_MASK_OFS);

  // Only a written one clears the flag; a written zero leaves it untouched.
  assign rx_threshold_flag_clear = wr_ctrl & hwdata_i[`CTRL_FLAG_CLR_BIT];

  // A held FIFO has its pointer at zero, so the block reports it as empty.
  assign rx_fifo_byte_count = rx_fifo_run_not_reset ? rx_fifo_byte_count_i : {CNT_W{1'b0}};

  // Address phase capture for reads and writes.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_write <= 1'b0;
      dp_addr <= {ADDR_W{1'b0}};
    end else if (hready_i) begin
      dp_write <= take & hwrite_i;
      if (take) begin
        dp_addr <= haddr_i;
      end
    end
  end

  // Reads take one wait state so that a write just before them is already visible.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take & ~hwrite_i) begin
          next_state = ST_RWAIT;
        end
      end
      ST_RWAIT: begin
        next_state = ST_RDONE;
      end
      ST_RDONE: begin
        if (take & ~hwrite_i) begin
          next_state = ST_RWAIT;
        end else begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // The read address is kept in dp_addr; a read never overlaps a write data phase.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h00000000;
    end else if (state == ST_RWAIT) begin
      hrdata_o <= read_word;
    end
  end

  assign hreadyout_o = (state != ST_RWAIT);
  assign hresp_o = `HRESP_OKAY;

  // The flag-clear bit and the reserved top bits read as zero.
  assign ctrl_word = {
    2'b00,
    rx_fifo_run_not_reset,
    rx_fifo_byte_count,
    rx_threshold_flag,
    1'b0,
    rx_threshold_irq_enable,
    rx_threshold_level
  };

  // Unmapped addresses read as zero and ignore writes.
  always @* begin
    read_word = 32'h00000000;
    case (dp_addr)
      `REG_CTRL_OFS: begin
        read_word = {16'h0000, ctrl_word};
      end
      `REG_EVT_STATUS_OFS: begin
        read_word[EVT_N-1:0] = evt_status;
      end
      `REG_EVT_MASK_OFS: begin
        read_word[EVT_N-1:0] = evt_mask;
      end
      default: begin
        read_word = 32'h00000000;
      end
    endcase
  end

  // Level and run bit written together take effect on the same edge, so no early flag occurs.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_threshold_level <= `RST_LEVEL;
      rx_threshold_irq_enable <= `RST_IRQ_EN;
      rx_fifo_run_not_reset <= `RST_RUN;
    end else if (wr_ctrl) begin
      rx_threshold_level <= hwdata_i[`CTRL_LEVEL_MSB:`CTRL_LEVEL_LSB];
      rx_threshold_irq_enable <= hwdata_i[`CTRL_IRQ_EN_BIT];
      rx_fifo_run_not_reset <= hwdata_i[`CTRL_RUN_BIT];
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_mask <= `RST_EVT_MASK;
    end else if (wr_mask) begin
      evt_mask <= hwdata_i[EVT_N-1:0];
    end
  end

  rx_threshold_flag #(
    .CNT_W(CNT_W)
  ) u_flag (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(rx_fifo_run_not_reset),
    .count_i(rx_fifo_byte_count),
    .level_i(rx_threshold_level),
    .clear_i(rx_threshold_flag_clear),
    .flag_o(rx_threshold_flag),
    .set_pulse_o(flag_set_pulse)
  );

  // Previous count, used to spot the cycle in which the FIFO fills or drains.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_prev <= {CNT_W{1'b0}};
    end else begin
      count_prev <= rx_fifo_byte_count;
    end
  end

  assign evt_pulse[`EVT_THRESHOLD] = flag_set_pulse;
  assign evt_pulse[`EVT_FULL] = (rx_fifo_byte_count == `FIFO_FULL_COUNT) &
                                (count_prev != `FIFO_FULL_COUNT);
  // A count above sixteen cannot come from a healthy FIFO and is reported once per entry.
  assign evt_pulse[`EVT_OVERFLOW] = (rx_fifo_byte_count > `FIFO_FULL_COUNT) &
                                    (count_prev <= `FIFO_FULL_COUNT);
  assign evt_pulse[`EVT_EMPTIED] = rx_fifo_run_not_reset &
                                   (rx_fifo_byte_count == {CNT_W{1'b0}}) &
                                   (count_prev != {CNT_W{1'b0}});

  assign evt_w1c = wr_status ? hwdata_i[EVT_N-1:0] : {EVT_N{1'b0}};

  // Each sticky event bit lets a new event win over a clear in the same cycle.
  genvar gi;
  generate
    for (gi = 0; gi < EVT_N; gi = gi + 1) begin : g_evt
      always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          evt_status[gi] <= 1'b0;
        end else if (evt_pulse[gi]) begin
          evt_status[gi] <= 1'b1;
        end else if (evt_w1c[gi]) begin
          evt_status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign rx_fifo_run_not_reset_o = rx_fifo_run_not_reset;
  assign rx_fifo_ptr_reset_o = ~rx_fifo_run_not_reset;
  assign rx_fifo_irq_o = rx_threshold_flag & rx_threshold_irq_enable;
  assign irq_o = |(evt_status & evt_mask);

  // The transfer size is not checked: only whole-word transfers are expected.
  wire unused_size;
  assign unused_size = |hsize_i;

endmodule
`default_nettype wire

/* bench/rx_fifo_level_chk.sv */
// Assertion checker for the receive FIFO level interrupt block.
`timescale 1ns/1ps
`default_nettype none
module rx_fifo_level_chk #(
  parameter ADDR_W = 12,
  parameter CNT_W = 5
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic rx_fifo_run_not_reset_o,
  input wire logic rx_fifo_ptr_reset_o,
  input wire logic rx_fifo_irq_o
);
  // High during the data phase of a write to the control register.
  logic wr_dp;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) wr_dp <= 1'b0;
    else if (hready_i) wr_dp <= hsel_i && htrans_i[1] && hwrite_i && haddr_i == '0;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd_take;
    hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  endsequence
  sequence s_rd_answer;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  a_read_wait: assert property (s_rd_take |=> s_rd_answer)
    else $error("read wait state wrong");
  a_write_nowait: assert property (hsel_i && htrans_i[1] && hready_i && hwrite_i |=> hreadyout_o)
    else $error("write was stalled");
  a_clr_reads_zero: assert property (s_rd_take ##1 s_rd_answer |-> hrdata_o[6] == 1'b0)
    else $error("clear bit read as one");
  a_resp_okay: assert property (hresp_o == 1'b0)
    else $error("response not okay");
  a_ptr_held: assert property (rx_fifo_ptr_reset_o == !rx_fifo_run_not_reset_o)
    else $error("pointer reset not inverse of run");
  a_run_by_write: assert property ($changed(rx_fifo_run_not_reset_o) |-> $past(wr_dp))
    else $error("run bit changed without write");
  a_irq_sticky: assert property ($fell(rx_fifo_irq_o) |-> $past(wr_dp))
    else $error("request fell without write");
  a_irq_cause: assert property ($rose(rx_fifo_irq_o) |-> $past(rx_fifo_run_not_reset_o) || $past(wr_dp))
    else $error("request rose without cause");
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// Directed testbench for the receive FIFO level interrupt block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [11:0] haddr_i = 12'h000;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [4:0] cnt = 5'h00;
  logic [31:0] r;
  wire hready_i;
  wire hresp_o;
  wire [31:0] hrdata_o;
  wire run;
  wire ptr;
  wire rxirq;
  wire irq;
  int mismatches = 0;
  int n_compared = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  rx_fifo_level_irq u_rx_fifo_level_irq (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hready_i),
    .hresp_o(hresp_o), .hrdata_o(hrdata_o), .rx_fifo_byte_count_i(cnt),
    .rx_fifo_run_not_reset_o(run), .rx_fifo_ptr_reset_o(ptr), .rx_fifo_irq_o(rxirq),
    .irq_o(irq));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    @(posedge sys_clk_i);
    while (hready_i !== 1'b1) @(posedge sys_clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    @(posedge sys_clk_i);
    while (hready_i !== 1'b1) @(posedge sys_clk_i);
    r = hrdata_o;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(r, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial begin
    cyc(8);
    rst_n_i <= 1'b1;
    cyc(1);
    rdc(12'h000, 32'h0);
    chk(ptr, 32'h1);
    bus(12'h00C, 1'b1, 32'hFFFFFFFF);
    rdc(12'h00C, 32'h0);
    rdc(12'h008, 32'h0);
    $display("test reset done");
    bus(12'h000, 1'b1, 32'h2024);
    cyc(2);
    chk(rxirq, 32'h0);
    rdc(12'h000, 32'h2024);
    chk(ptr, 32'h0);
    cnt <= 5'h03;
    cyc(3);
    chk(rxirq, 32'h0);
    cnt <= 5'h04;
    cyc(3);
    chk(rxirq, 32'h1);
    rdc(12'h000, 32'h24A4);
    cnt <= 5'h01;
    bus(12'h000, 1'b1, 32'h2024);
    cyc(2);
    chk(rxirq, 32'h1);
    bus(12'h000, 1'b1, 32'h2004);
    cyc(1);
    chk(rxirq, 32'h0);
    rdc(12'h000, 32'h2184);
    bus(12'h000, 1'b1, 32'h2064);
    rdc(12'h000, 32'h2124);
    $display("test threshold done");
    cnt <= 5'h10;
    cyc(3);
    rdc(12'h000, 32'h30A4);
    bus(12'h004, 1'b0, 32'h0);
    chk(r & 32'h3, 32'h3);
    chk(irq, 32'h0);
    bus(12'h008, 1'b1, 32'h1);
    cyc(1);
    chk(irq, 32'h1);
    bus(12'h004, 1'b1, 32'hF);
    cyc(1);
    chk(irq, 32'h0);
    rdc(12'h004, 32'h0);
    cnt <= 5'h11;
    cyc(2);
    cnt <= 5'h00;
    cyc(2);
    rdc(12'h004, 32'hC);
    bus(12'h004, 1'b1, 32'hF);
    $display("test events done");
    cnt <= 5'h05;
    // The count is still above the level while run is high, so the set wins over this clear.
    bus(12'h000, 1'b1, 32'h0040);
    rdc(12'h000, 32'h0080);
    bus(12'h000, 1'b1, 32'h0040);
    rdc(12'h000, 32'h0);
    cnt <= 5'h00;
    bus(12'h000, 1'b1, 32'h2020);
    cyc(2);
    chk(rxirq, 32'h1);
    $display("test enable done");
    wrap_up();
  end
endmodule
bind rx_fifo_level_irq rx_fifo_level_chk #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_rx_fifo_level_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
  .rx_fifo_run_not_reset_o(rx_fifo_run_not_reset_o),
  .rx_fifo_ptr_reset_o(rx_fifo_ptr_reset_o), .rx_fifo_irq_o(rx_fifo_irq_o));
`default_nettype wire
